/* hw/gpio_clock_mask_live_insert.sv */
// GPIO port, secondary clock-mask shift-in and live-insertion masking
//
// Behaviour
// - Writing 1 to a drive-enable set bit makes that pin a driven output.
// - Writing 1 to a drive-enable clear bit tristates that pin.
// - Zero bits in any set or clear field change nothing.
// - After reset all pins are inputs and stored output value is zero.
// - Level readback always returns live pin levels, whatever the direction.
// - Writing 1 to an output-value set bit makes the pin drive high.
// - Writing 1 to an output-value clear bit makes the pin drive low.
// - Stored output value reaches a pin only while that pin is enabled.
// - Mask shift-in starts once primary reset releases with secondary reset held.
// - Secondary reset stays asserted until the 23-step mask sequence ends.
// - Pin 0 is the shift clock at most 33 MHz; pins 1, 3 unused.
// - Pin 2 low one step to parallel-load, then high to shift.
// - Serial mask arrives most significant bit first.
// - Mask pairs [7:0] gate clocks 3..0; enabled if either bit is zero.
// - Mask bits 8..12 gate clocks 4..8; zero enables, one disables.
// - Mask bit 13 gates clock 9 (own return); bits 14, 15 do nothing.
// - After shifting, pins tristate, mask input ignored, registers regain control.
// - Clock mask stays writable by configuration write afterwards.
// - Live mode, pin 3 input, pin 3 high forces I/O, memory, master enables off.
// - Reads still show stored enables; effective enables return when pin 3 falls.
// - During halt, queued work finishes, no delayed completions, config still served.
// - Secondary reset bit holds secondary reset until software clears it.
`timescale 1ns/1ps

module gpio_clock_mask_live_insert #(
    parameter int unsigned NUM_CLOCKS = 10
) (
    input  wire logic                          mclk_in,
    input  wire logic                          reset_n_in,
    input  wire gpio_clock_mask_pkg::cfg_req_t cfg_req_in,
    output gpio_clock_mask_pkg::cfg_rsp_t      cfg_rsp_out,
    input  wire logic [3:0]                    gpio_in,
    output logic [3:0]                         gpio_out,
    output logic [3:0]                         gpio_oe_n_out,
    input  wire logic                          clock_mask_serial_in,
    input  wire logic                          secondary_clock_src_in,
    output logic [NUM_CLOCKS-1:0]              secondary_clock_out,
    output logic                               secondary_reset_n_out,
    output gpio_clock_mask_pkg::fwd_ctrl_t     fwd_ctrl_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    gpio_clock_mask_pkg::regs_t q;
    gpio_clock_mask_pkg::regs_t d;
    logic                       shift_step;
    logic                       in_load;
    logic [31:0]                rd_word;
    logic [NUM_CLOCKS-1:0]      clk_en;
    logic                       halt;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= gpio_clock_mask_pkg::REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d          = q;
        rd_word    = 32'h0000_0000;
        shift_step = (q.step >= gpio_clock_mask_pkg::STEP_SHIFT_FIRST) &&
                     (q.step <= gpio_clock_mask_pkg::STEP_SHIFT_LAST);

        // Pin and mask inputs come from off chip
        d.mask_s1 = clock_mask_serial_in;
        d.mask_s2 = q.mask_s1;
        d.pin_s1  = gpio_in;
        d.pin_s2  = q.pin_s1;

        // Mask load: the reset state is the load state, so it starts on release
        case (q.state)
            gpio_clock_mask_pkg::ST_MASK_LOAD: begin
                d.phase = q.phase + 2'h1;
                if (q.phase == gpio_clock_mask_pkg::PHASE_LAST) begin
                    if (shift_step) begin
                        // Sampled pin level predates this step's rising edge
                        d.clock_mask = {q.clock_mask[14:0], q.mask_s2};
                    end
                    if (q.step == gpio_clock_mask_pkg::STEP_SEQ_LAST) begin
                        d.state = gpio_clock_mask_pkg::ST_NORMAL;
                        d.step  = gpio_clock_mask_pkg::STEP_LOAD;
                    end else begin
                        d.step = q.step + 5'h01;
                    end
                end
            end
            gpio_clock_mask_pkg::ST_NORMAL: begin
                d.phase = 2'h0;
            end
            default: begin
                d.state = gpio_clock_mask_pkg::ST_MASK_LOAD;
                d.step  = gpio_clock_mask_pkg::STEP_LOAD;
                d.phase = 2'h0;
            end
        endcase

        // --------------------------------------------------------------
        // Configuration writes
        // --------------------------------------------------------------
        if (cfg_req_in.wr) begin
            case (cfg_req_in.addr)
                gpio_clock_mask_pkg::REG_PIN_CTRL: begin
                    // Set before clear: a bit in both fields ends cleared
                    if (cfg_req_in.be[0]) begin
                        d.pin_out_val = d.pin_out_val |
                            cfg_req_in.wdata[gpio_clock_mask_pkg::OUT_SET_LSB +: 4];
                    end
                    if (cfg_req_in.be[1]) begin
                        d.pin_out_val = d.pin_out_val &
                            ~cfg_req_in.wdata[gpio_clock_mask_pkg::OUT_CLR_LSB +: 4];
                    end
                    if (cfg_req_in.be[2]) begin
                        d.pin_drv_en = d.pin_drv_en |
                            cfg_req_in.wdata[gpio_clock_mask_pkg::DRV_SET_LSB +: 4];
                    end
                    if (cfg_req_in.be[3]) begin
                        d.pin_drv_en = d.pin_drv_en &
                            ~cfg_req_in.wdata[gpio_clock_mask_pkg::DRV_CLR_LSB +: 4];
                    end
                end
                gpio_clock_mask_pkg::REG_CLOCK_MASK: begin
                    // Ignored mid-load so software cannot corrupt the shift
                    if (q.state == gpio_clock_mask_pkg::ST_NORMAL) begin
                        if (cfg_req_in.be[0]) begin
                            d.clock_mask[7:0] = cfg_req_in.wdata[7:0];
                        end
                        if (cfg_req_in.be[1]) begin
                            d.clock_mask[15:8] = cfg_req_in.wdata[15:8];
                        end
                    end
                end
                gpio_clock_mask_pkg::REG_COMMAND: begin
                    if (cfg_req_in.be[0]) begin
                        d.command = cfg_req_in.wdata[2:0];
                    end
                end
                gpio_clock_mask_pkg::REG_BRIDGE_CTRL: begin
                    if (cfg_req_in.be[2]) begin
                        d.sec_reset_bit =
                            cfg_req_in.wdata[gpio_clock_mask_pkg::SEC_RESET_BIT];
                    end
                end
                gpio_clock_mask_pkg::REG_CHIP_CTRL: begin
                    if (cfg_req_in.be[0]) begin
                        d.live_mode = cfg_req_in.wdata[gpio_clock_mask_pkg::LIVE_MODE_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Configuration reads: answered one cycle later, always served
        // --------------------------------------------------------------
        case (cfg_req_in.addr)
            gpio_clock_mask_pkg::REG_PIN_CTRL: begin
                rd_word[gpio_clock_mask_pkg::OUT_SET_LSB +: 4] = q.pin_out_val;
                rd_word[gpio_clock_mask_pkg::OUT_CLR_LSB +: 4] = q.pin_out_val;
                rd_word[gpio_clock_mask_pkg::DRV_SET_LSB +: 4] = q.pin_drv_en;
                rd_word[gpio_clock_mask_pkg::DRV_CLR_LSB +: 4] = q.pin_drv_en;
            end
            gpio_clock_mask_pkg::REG_PIN_LEVEL: begin
                rd_word[3:0] = q.pin_s2;
            end
            gpio_clock_mask_pkg::REG_CLOCK_MASK: begin
                rd_word[15:0] = q.clock_mask;
            end
            gpio_clock_mask_pkg::REG_COMMAND: begin
                rd_word[2:0] = q.command;
            end
            gpio_clock_mask_pkg::REG_BRIDGE_CTRL: begin
                rd_word[gpio_clock_mask_pkg::SEC_RESET_BIT] = q.sec_reset_bit;
            end
            gpio_clock_mask_pkg::REG_CHIP_CTRL: begin
                rd_word[gpio_clock_mask_pkg::LIVE_MODE_BIT] = q.live_mode;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
        d.rsp_valid = cfg_req_in.rd;
        d.rsp_data  = cfg_req_in.rd ? rd_word : 32'h0000_0000;

        // --------------------------------------------------------------
        // Pin drive, registered from the next state
        // --------------------------------------------------------------
        if (d.state == gpio_clock_mask_pkg::ST_MASK_LOAD) begin
            // Pins 0 and 2 driven, 1 and 3 left floating
            d.pin_oe_n     = 4'b1010;
            d.pin_drive[1] = 1'b0;
            d.pin_drive[3] = 1'b0;
            d.pin_drive[2] = (d.step != gpio_clock_mask_pkg::STEP_LOAD);
            d.pin_drive[0] = d.phase[1] &&
                             (d.step >= gpio_clock_mask_pkg::STEP_SHIFT_FIRST) &&
                             (d.step <= gpio_clock_mask_pkg::STEP_SHIFT_LAST);
        end else begin
            d.pin_oe_n  = ~d.pin_drv_en;
            d.pin_drive = d.pin_out_val & d.pin_drv_en;
        end
    end

    // ------------------------------------------------------------------
    // Secondary clock gating
    // ------------------------------------------------------------------
    always_comb begin
        clk_en = '0;
        for (int i = 0; i < 4; i++) begin
            clk_en[i] = ~(q.clock_mask[2*i] & q.clock_mask[2*i+1]);
        end
        for (int i = 4; i < 9; i++) begin
            clk_en[i] = ~q.clock_mask[i+4];
        end
        clk_en[9] = ~q.clock_mask[13];
    end

    // Combinational gate: clock path must not pick up a flop delay
    assign secondary_clock_out = {NUM_CLOCKS{secondary_clock_src_in}} |
                                 ~clk_en;

    // ------------------------------------------------------------------
    // Secondary reset and live insertion
    // ------------------------------------------------------------------
    assign in_load = (q.state == gpio_clock_mask_pkg::ST_MASK_LOAD);
    assign secondary_reset_n_out = ~(in_load | q.sec_reset_bit);

    assign halt = q.live_mode &&
                  !q.pin_drv_en[gpio_clock_mask_pkg::LIVE_PIN] &&
                  q.pin_s2[gpio_clock_mask_pkg::LIVE_PIN];

    assign fwd_ctrl_out.io_en     = q.command[gpio_clock_mask_pkg::CMD_IO_BIT] & ~halt;
    assign fwd_ctrl_out.mem_en    = q.command[gpio_clock_mask_pkg::CMD_MEM_BIT] & ~halt;
    assign fwd_ctrl_out.master_en = q.command[gpio_clock_mask_pkg::CMD_MASTER_BIT] & ~halt;
    assign fwd_ctrl_out.halt      = halt;

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign gpio_out          = q.pin_drive;
    assign gpio_oe_n_out     = q.pin_oe_n;
    assign cfg_rsp_out.valid = q.rsp_valid;
    assign cfg_rsp_out.rdata = q.rsp_data;

endmodule

/* common/gpio_clock_mask_pkg.sv */
// Package: constants, register map and state types for the GPIO / clock-mask block
package gpio_clock_mask_pkg;

    // ------------------------------------------------------------------
    // Clocking and mask-load timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 20;
    localparam int unsigned SHIFT_CLK_MAX_MHZ  = 33;
    // Least mclk cycles per shift-clock period allowed by the 33 MHz ceiling
    localparam int unsigned SHIFT_MIN_CYCLES   =
        (CLK_MHZ + SHIFT_CLK_MAX_MHZ - 1) / SHIFT_CLK_MAX_MHZ;
    // Four phases per step: slow enough that the resynchronised serial bit
    // is sampled before the shift-clock rising edge that advances it
    localparam int unsigned SHIFT_DIV          = 4;
    localparam logic [1:0]  PHASE_LAST         = 2'h3;
    localparam int unsigned MASK_BITS          = 16;
    localparam int unsigned SEQ_STEPS          = 23;
    localparam logic [4:0]  STEP_LOAD          = 5'h00;
    localparam logic [4:0]  STEP_SHIFT_FIRST   = 5'h02;
    localparam logic [4:0]  STEP_SHIFT_LAST    = 5'h11;
    localparam logic [4:0]  STEP_SEQ_LAST      = 5'h16;

    // ------------------------------------------------------------------
    // Configuration register map (dword byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_COMMAND        = 8'h04;
    localparam logic [7:0]  REG_BRIDGE_CTRL    = 8'h3C;
    localparam logic [7:0]  REG_CHIP_CTRL      = 8'h40;
    localparam logic [7:0]  REG_PIN_CTRL       = 8'h64;
    localparam logic [7:0]  REG_PIN_LEVEL      = 8'h68;
    localparam logic [7:0]  REG_CLOCK_MASK     = 8'h6C;

    // Field positions
    localparam int unsigned OUT_SET_LSB        = 0;
    localparam int unsigned OUT_CLR_LSB        = 8;
    localparam int unsigned DRV_SET_LSB        = 16;
    localparam int unsigned DRV_CLR_LSB        = 24;
    localparam int unsigned SEC_RESET_BIT      = 22;
    localparam int unsigned LIVE_MODE_BIT      = 0;
    localparam int unsigned CMD_IO_BIT         = 0;
    localparam int unsigned CMD_MEM_BIT        = 1;
    localparam int unsigned CMD_MASTER_BIT     = 2;
    localparam int unsigned LIVE_PIN           = 3;

    // Reset values
    localparam logic [3:0]  PIN_OUT_RESET      = 4'h0;
    localparam logic [3:0]  PIN_DRV_RESET      = 4'h0;
    localparam logic [15:0] CLOCK_MASK_RESET   = 16'h0000;
    localparam logic [2:0]  COMMAND_RESET      = 3'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_MASK_LOAD = 2'b01,
        ST_NORMAL    = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic        io_en;
        logic        mem_en;
        logic        master_en;
        logic        halt;
    } fwd_ctrl_t;

    typedef struct packed {
        seq_state_t  state;
        logic [4:0]  step;
        logic [1:0]  phase;
        logic [3:0]  pin_out_val;
        logic [3:0]  pin_drv_en;
        logic [15:0] clock_mask;
        logic [2:0]  command;
        logic        sec_reset_bit;
        logic        live_mode;
        logic        mask_s1;
        logic        mask_s2;
        logic [3:0]  pin_s1;
        logic [3:0]  pin_s2;
        logic [3:0]  pin_drive;
        logic [3:0]  pin_oe_n;
        logic        rsp_valid;
        logic [31:0] rsp_data;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        state:         ST_MASK_LOAD,
        step:          STEP_LOAD,
        phase:         2'h0,
        pin_out_val:   PIN_OUT_RESET,
        pin_drv_en:    PIN_DRV_RESET,
        clock_mask:    CLOCK_MASK_RESET,
        command:       COMMAND_RESET,
        sec_reset_bit: 1'b0,
        live_mode:     1'b0,
        mask_s1:       1'b0,
        mask_s2:       1'b0,
        pin_s1:        4'h0,
        pin_s2:        4'h0,
        pin_drive:     4'h0,
        pin_oe_n:      4'hF,
        rsp_valid:     1'b0,
        rsp_data:      32'h0000_0000
    };

endpackage

/* dv/gpio_clock_mask_asserts.sv */
// Port-level assertions for the GPIO / clock-mask block
`timescale 1ns/1ps
module gpio_clock_mask_checker #(
    parameter int unsigned NUM_CLOCKS = 10
) (
    input wire logic                           mclk_in,
    input wire logic                           reset_n_in,
    input wire gpio_clock_mask_pkg::cfg_req_t  cfg_req_in,
    input wire gpio_clock_mask_pkg::cfg_rsp_t  cfg_rsp_out,
    input wire logic [3:0]                     gpio_in,
    input wire logic [3:0]                     gpio_out,
    input wire logic [3:0]                     gpio_oe_n_out,
    input wire logic                           clock_mask_serial_in,
    input wire logic                           secondary_clock_src_in,
    input wire logic [NUM_CLOCKS-1:0]          secondary_clock_out,
    input wire logic                           secondary_reset_n_out,
    input wire gpio_clock_mask_pkg::fwd_ctrl_t fwd_ctrl_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic [6:0] cnt_q;
    logic [3:0] drv_set;
    logic [3:0] drv_clr;
    logic [3:0] val_set;
    logic [3:0] val_clr;
    logic       pin_wr;
    assign drv_set = cfg_req_in.wdata[19:16];
    assign drv_clr = cfg_req_in.wdata[27:24];
    assign val_set = cfg_req_in.wdata[3:0];
    assign val_clr = cfg_req_in.wdata[11:8];
    // Only full writes after the load, where pins follow the registers
    assign pin_wr = cfg_req_in.wr && cfg_req_in.be == 4'hF && cnt_q == 7'h7F
        && cfg_req_in.addr == gpio_clock_mask_pkg::REG_PIN_CTRL;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= 7'h00;
        end else if (cnt_q != 7'h7F) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    load_pins_a: assert property (cnt_q inside {[7'h02:7'h58]} |-> gpio_oe_n_out == 4'hA)
        else $error("pin directions wrong during mask load");
    sreset_hold_a: assert property (cnt_q < 7'h5A |-> !secondary_reset_n_out)
        else $error("secondary reset released during mask load");
    load_pulse_a: assert property (cnt_q inside {[7'h01:7'h03]} |-> !gpio_out[2])
        else $error("load control not low at start of mask load");
    shift_mode_a: assert property (cnt_q inside {[7'h06:7'h58]} |-> gpio_out[2])
        else $error("shift control not high during shifting");
    shift_clk_a: assert property (cnt_q < 7'h5A && $rose(gpio_out[0]) |=>
        gpio_out[0] ##1 !gpio_out[0] [*2]) else $error("shift clock waveform wrong");
    drive_set_a: assert property (pin_wr |=>
        (gpio_oe_n_out & $past(drv_set) & ~$past(drv_clr)) == 4'h0)
        else $error("pin not driven after enable set");
    drive_clear_a: assert property (pin_wr |=> (~gpio_oe_n_out & $past(drv_clr)) == 4'h0)
        else $error("pin still driven after enable clear");
    zero_bits_a: assert property (pin_wr |=>
        ((gpio_oe_n_out ^ $past(gpio_oe_n_out)) & ~($past(drv_set) | $past(drv_clr))) == 4'h0)
        else $error("untouched pin direction changed");
    out_value_a: assert property (pin_wr |=> (~gpio_oe_n_out &
        (($past(val_set) & ~$past(val_clr) & ~gpio_out) | ($past(val_clr) & gpio_out))) == 4'h0)
        else $error("driven pin value wrong after write");
    read_answer_a: assert property (cfg_rsp_out.valid == $past(cfg_req_in.rd))
        else $error("read answer not exactly one cycle after request");
    halt_mask_a: assert property (fwd_ctrl_out.halt |-> gpio_oe_n_out[3] &&
        !(fwd_ctrl_out.io_en | fwd_ctrl_out.mem_en | fwd_ctrl_out.master_en))
        else $error("enables not masked during halt");
    cover property (pin_wr);
    cover property (fwd_ctrl_out.halt);
    cover property (cnt_q == 7'h5E && secondary_reset_n_out);
endmodule

bind gpio_clock_mask_live_insert gpio_clock_mask_checker #(
    .NUM_CLOCKS(NUM_CLOCKS)
) checker_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_req_in(cfg_req_in),
    .cfg_rsp_out(cfg_rsp_out), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n_out(gpio_oe_n_out), .clock_mask_serial_in(clock_mask_serial_in),
    .secondary_clock_src_in(secondary_clock_src_in), .secondary_clock_out(secondary_clock_out),
    .secondary_reset_n_out(secondary_reset_n_out), .fwd_ctrl_out(fwd_ctrl_out)
);

/* dv/shift_reg_model.sv */
// External parallel-load serial shift register feeding the mask input
`timescale 1ns/1ps
module shift_reg_model (
    input  wire logic        shift_clk_in,
    input  wire logic        load_shift_in,
    input  wire logic [15:0] load_value_in,
    output logic             serial_out
);
    logic [15:0] sr_q;
    // Load is a level, so it wins even with no clock edge in the pulse
    always @(posedge shift_clk_in or negedge load_shift_in) begin
        if (!load_shift_in) begin
            sr_q <= load_value_in;
        end else begin
            // Refill with a changing pattern so stale bits never look valid
            sr_q <= {sr_q[14:0], ~sr_q[15]};
        end
    end
    assign serial_out = sr_q[15];
endmodule

/* dv/test_gpio_clock_mask_live_insert.sv */
// Self-checking bench for the GPIO / clock-mask block
`timescale 1ns/1ps
module test_gpio_clock_mask_live_insert;
    logic                           mclk_in = 1'b0;
    logic                           reset_n_in = 1'b0;
    logic                           serial, sres_n;
    logic                           tie_hi = 1'b0;
    gpio_clock_mask_pkg::cfg_req_t  req = '0;
    gpio_clock_mask_pkg::cfg_rsp_t  rsp;
    gpio_clock_mask_pkg::fwd_ctrl_t fwd;
    logic [3:0]                     gout, oe_n, pins;
    logic [3:0]                     ext = 4'h0, drv = 4'h0, outv = 4'h0;
    logic [9:0]                     sclk;
    logic [15:0]                    mask_val = 16'h0000;
    logic [31:0]                    w;
    logic [63:0]                    e;
    logic [63:0]                    exp_q[$];
    int                             errors = 0;
    int                             checks = 0;
    int                             n;
    // Undriven pins show the board's value, driven ones the block's
    assign pins = (oe_n & ext) | (~oe_n & gout);
    gpio_clock_mask_live_insert uut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_req_in(req), .cfg_rsp_out(rsp),
        .gpio_in(pins), .gpio_out(gout), .gpio_oe_n_out(oe_n),
        .clock_mask_serial_in(serial | tie_hi), .secondary_clock_src_in(mclk_in),
        .secondary_clock_out(sclk), .secondary_reset_n_out(sres_n), .fwd_ctrl_out(fwd)
    );
    shift_reg_model partner (
        .shift_clk_in(pins[0]), .load_shift_in(pins[2]), .load_value_in(mask_val),
        .serial_out(serial)
    );
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (exp !== got) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (exp_q.size() != 0) errors++;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cfg_wr(logic [7:0] a, logic [31:0] d);
        @(negedge mclk_in);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hF, wdata: d};
        @(negedge mclk_in);
        req.wr = 1'b0;
    endtask
    task automatic cfg_rd(logic [7:0] a, logic [31:0] exp, logic [31:0] m);
        @(negedge mclk_in);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0000_0000};
        exp_q.push_back({m, exp & m});
        @(negedge mclk_in);
        req.rd = 1'b0;
    endtask
    task automatic clk_check(logic [15:0] m);
        logic [9:0] dis;
        for (int i = 0; i < 4; i++) dis[i] = m[2*i] & m[2*i+1];
        dis[8:4] = m[12:8];
        dis[9] = m[13];
        @(negedge mclk_in);
        #1 check("clock outputs low phase", {22'h00_0000, dis}, {22'h00_0000, sclk});
        @(posedge mclk_in);
        #1 check("clock outputs high phase", 32'h0000_03FF, {22'h00_0000, sclk});
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and read-answer scoreboard
    // ------------------------------------------------------------------
    initial forever #25 mclk_in = ~mclk_in;
    initial begin
        #200_000;
        errors++;
        end_sim();
    end
    always @(negedge mclk_in) begin
        if (rsp.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected read answer", 32'h0000_0000, 32'h0000_0001);
            end else begin
                e = exp_q.pop_front();
                check("read data", e[31:0], rsp.rdata & e[63:32]);
            end
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        w = $urandom(32'hB001);
        mask_val = 16'($urandom());
        ext = 4'($urandom());
        repeat (3) @(negedge mclk_in);
        check("reset pin state", 32'h0000_00F0, {24'h00_0000, oe_n, gout});
        check("reset secondary reset", 32'h0000_0000, {31'h0000_0000, sres_n});
        reset_n_in = 1'b1;
        n = 0;
        while (sres_n !== 1'b1 && n < 200) begin
            @(posedge mclk_in);
            #1 n++;
        end
        if (n == 200) begin
            errors++;
            end_sim();
        end
        check("load length", 32'h0000_0001, 32'(n >= 92 && n <= 93));
        check("pins released", 32'h0000_000F, {28'h000_0000, oe_n});
        cfg_rd(gpio_clock_mask_pkg::REG_CLOCK_MASK, mask_val, 32'h0000_FFFF);
        clk_check(mask_val);
        for (int k = 0; k < 12; k++) begin
            w = (k == 0) ? 32'h0F0F_0F0F : $urandom() & 32'h0F0F_0F0F;
            ext = 4'($urandom());
            cfg_wr(gpio_clock_mask_pkg::REG_PIN_CTRL, w);
            outv = (outv | w[3:0]) & ~w[11:8];
            drv = (drv | w[19:16]) & ~w[27:24];
            repeat (3) @(negedge mclk_in);
            check("pin enables", {28'h000_0000, ~drv}, {28'h000_0000, oe_n});
            check("pin values", outv & drv, gout & drv);
            cfg_rd(gpio_clock_mask_pkg::REG_PIN_LEVEL, pins, 32'h0000_000F);
            cfg_rd(gpio_clock_mask_pkg::REG_PIN_CTRL, {{2{4'h0, drv}}, {2{4'h0, outv}}},
                32'h0F0F_0F0F);
        end
        cfg_rd(gpio_clock_mask_pkg::REG_CLOCK_MASK, mask_val, 32'h0000_FFFF);
        w = $urandom();
        cfg_wr(gpio_clock_mask_pkg::REG_CLOCK_MASK, w);
        cfg_rd(gpio_clock_mask_pkg::REG_CLOCK_MASK, w, 32'h0000_FFFF);
        clk_check(w[15:0]);
        cfg_wr(gpio_clock_mask_pkg::REG_PIN_CTRL, 32'h0800_0000);
        cfg_wr(gpio_clock_mask_pkg::REG_COMMAND, 32'h0000_0007);
        cfg_wr(gpio_clock_mask_pkg::REG_CHIP_CTRL, 32'h0000_0001);
        ext = 4'h8;
        repeat (4) @(negedge mclk_in);
        check("halted enables", 32'h0000_0001, {28'h000_0000, fwd});
        cfg_rd(gpio_clock_mask_pkg::REG_COMMAND, 32'h0000_0007, 32'h0000_0007);
        ext = 4'h0;
        repeat (4) @(negedge mclk_in);
        check("restored enables", 32'h0000_000E, {28'h000_0000, fwd});
        cfg_wr(gpio_clock_mask_pkg::REG_PIN_CTRL, 32'h0008_0000);
        ext = 4'h8;
        repeat (4) @(negedge mclk_in);
        check("driven pin no halt", 32'h0000_000E, {28'h000_0000, fwd});
        cfg_wr(gpio_clock_mask_pkg::REG_BRIDGE_CTRL, 32'h0040_0000);
        repeat (12) @(negedge mclk_in);
        check("reset bit holds", 32'h0000_0000, {31'h0000_0000, sres_n});
        cfg_wr(gpio_clock_mask_pkg::REG_BRIDGE_CTRL, 32'h0000_0000);
        repeat (3) @(negedge mclk_in);
        check("reset bit cleared", 32'h0000_0001, {31'h0000_0000, sres_n});
        tie_hi = 1'b1;
        reset_n_in = 1'b0;
        @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (96) @(negedge mclk_in);
        cfg_rd(gpio_clock_mask_pkg::REG_CLOCK_MASK, 32'h0000_FFFF, 32'h0000_FFFF);
        clk_check(16'hFFFF);
        end_sim();
    end
endmodule
